//--- rtl/ppo_pkg.sv
// constants, types and register layout for the parallel sample output port
// assumes one core clock domain; the port clock is sampled or generated in it
// Operation
// R1: single control bit selects port clock master/slave
// R2: master clock is core clock divided 1/2/4/8; at divide by 1 the code holds the pin high
// R3: slave port clock may be asynchronous
// R4: port clock pin is input after reset
// R5: port pins change only at port clock rise
// R6: request high while a sample waits
// R7: request stays high until all pending words sent
// R8: accept low stalls the data output
// R9: accept high sends words in programmed format order
// R10: accept sampled at port clock rising edge
// R11: first word within 1.5 port cycles of accept
// R12: accept held high: data one cycle after request
// R13: in-phase flag high only with in-phase word
// R14: packed format raises in-phase flag each cycle; the code drops the flag for the appended gain word
// R15: gain flag high only with gain word
// R16: 3-bit channel number shown with each word
// R17: sample words are two's complement
// R18: 8-bit components packed, 16-bit interleaved
// R19: interleaved order in-phase, quadrature, then gain
// R20: packed: in-phase upper byte, quadrature lower byte
// R21: channel 0 highest priority through channel 5
// R22: format bit, channel enables, gain append bit
// R23: accept drop holds word, resumes afterward
package ppo_pkg;

    localparam int NUM_CH   = 6;
    localparam int CH_W     = 3;
    localparam int WORD_W   = 16;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;

    // control word: [0] packed format, [1] gain append, [7:2] channel enables,
    // [8] clock master, [10:9] divisor code
    localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTRL_WR_MASK = 32'h0000_07ff;

    // status word fields
    localparam int STAT_PEND_LSB = 0;
    localparam int STAT_REQ_BIT  = 8;
    localparam int STAT_CH_LSB   = 16;

    // divisor codes 0..3 mean 1, 2, 4, 8; terminal count per code
    localparam logic [2:0] DIV_MAX_1 = 3'h0;
    localparam logic [2:0] DIV_MAX_2 = 3'h1;
    localparam logic [2:0] DIV_MAX_4 = 3'h3;
    localparam logic [2:0] DIV_MAX_8 = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [20:0] rsvd;
        logic [1:0]  div;
        logic        master;
        logic [5:0]  ch_en;
        logic        gain_en;
        logic        fmt_packed;
    } ppo_ctrl_s;

    typedef struct packed {
        logic [WORD_W-1:0] i;
        logic [WORD_W-1:0] q;
        logic [WORD_W-1:0] gain;
    } ppo_sample_s;

    typedef struct packed {
        logic              req;
        logic              iq;
        logic              gain;
        logic [CH_W-1:0]   ch;
        logic [WORD_W-1:0] data;
    } ppo_port_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_I,
        PH_Q,
        PH_G
    } ppo_phase_e;

endpackage : ppo_pkg

//--- rtl/ppo_sync.sv
// two-stage level synchroniser for asynchronous pins
// assumes the inputs are plain levels; no pulse narrower than a core cycle
`timescale 1ns/1ps
module ppo_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } ppo_sync_s;

    ppo_sync_s st;
    ppo_sync_s next_st;

    // first stage feeds only the second
    always_comb begin
        next_st    = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.s2;

endmodule : ppo_sync

//--- rtl/ppo_port.sv
// parallel sample output port with six channel holding slots and AXI4-Lite control
// assumes channel sources hold valid and data until ready; one core clock
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ppo_port (
    // clock and reset
    input  wire logic                               CLK_SYS_I,
    input  wire logic                               RST_I,
    // axi4-lite slave
    input  wire logic                               AXI_AWVALID_I,
    output logic                                    AXI_AWREADY_O,
    input  wire logic [ppo_pkg::ADDR_W-1:0]         AXI_AWADDR_I,
    input  wire logic                               AXI_WVALID_I,
    output logic                                    AXI_WREADY_O,
    input  wire logic [ppo_pkg::DATA_W-1:0]         AXI_WDATA_I,
    input  wire logic [3:0]                         AXI_WSTRB_I,
    output logic                                    AXI_BVALID_O,
    input  wire logic                               AXI_BREADY_I,
    output logic      [1:0]                         AXI_BRESP_O,
    input  wire logic                               AXI_ARVALID_I,
    output logic                                    AXI_ARREADY_O,
    input  wire logic [ppo_pkg::ADDR_W-1:0]         AXI_ARADDR_I,
    output logic                                    AXI_RVALID_O,
    input  wire logic                               AXI_RREADY_I,
    output logic      [ppo_pkg::DATA_W-1:0]         AXI_RDATA_O,
    output logic      [1:0]                         AXI_RRESP_O,
    // channel samples
    input  wire logic [ppo_pkg::NUM_CH-1:0]         SMP_VALID_I,
    input  wire ppo_pkg::ppo_sample_s [5:0]         SMP_DATA_I,
    output logic      [ppo_pkg::NUM_CH-1:0]         SMP_READY_O,
    // port clock pin
    input  wire logic                               PCLK_I,
    output logic                                    PCLK_O,
    output logic                                    PCLK_OE_O,
    // port pins
    input  wire logic                               SAMPLE_ACCEPT_I,
    output logic                                    SAMPLE_REQUEST_O,
    output logic                                    INPHASE_WORD_FLAG_O,
    output logic                                    GAIN_WORD_FLAG_O,
    output logic      [ppo_pkg::CH_W-1:0]           SOURCE_CHANNEL_ID_O,
    output logic      [ppo_pkg::WORD_W-1:0]         OUTPUT_WORD_BUS_O
);

    typedef struct packed {
        ppo_pkg::ppo_ctrl_s             ctrl;
        logic [5:0]                     pending;
        ppo_pkg::ppo_sample_s [5:0]     held;
        logic [2:0]                     div_cnt;
        logic                           pclk_pin;
        logic                           pclk_prev;
        ppo_pkg::ppo_phase_e            phase;
        ppo_pkg::ppo_port_s             port;
        logic                           aw_got;
        logic [ppo_pkg::ADDR_W-1:0]     aw_addr;
        logic                           w_got;
        logic [ppo_pkg::DATA_W-1:0]     w_data;
        logic [3:0]                     w_strb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [ppo_pkg::DATA_W-1:0]     rdata;
        logic [1:0]                     rresp;
    } ppo_state_s;

    ppo_state_s st;
    ppo_state_s next_st;

    logic [1:0]                   sync_out;
    logic                         pclk_sync;
    logic                         ack_sync;
    logic                         tick;
    logic [5:0]                   en_pend;
    logic [2:0]                   div_max;
    logic [ppo_pkg::DATA_W-1:0]   stat_word;

    // accept and slave clock are both asynchronous to the core
    ppo_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_i   (CLK_SYS_I),
        .rst_i   (RST_I),
        .async_i ({SAMPLE_ACCEPT_I, PCLK_I}),
        .sync_o  (sync_out)
    );

    assign pclk_sync = sync_out[0]; // R3
    assign ack_sync  = sync_out[1]; // R10

    // lowest index wins
    function automatic logic [2:0] first_ch(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int c = ppo_pkg::NUM_CH - 1; c >= 0; c--) begin
            if (v[c]) begin
                idx = 3'(c); // R21
            end
        end
        return idx;
    endfunction : first_ch

    function automatic ppo_pkg::ppo_port_s load_word(
        input ppo_pkg::ppo_phase_e  ph,
        input logic [2:0]           ch,
        input ppo_pkg::ppo_sample_s smp,
        input logic                 packed_fmt
    );
        ppo_pkg::ppo_port_s w;
        w      = '0;
        w.req  = 1'b1;
        w.iq   = (ph == ppo_pkg::PH_I); // R13 R14
        w.gain = (ph == ppo_pkg::PH_G); // R15
        w.ch   = ch; // R16
        case (ph)
            ppo_pkg::PH_I: begin
                // top bytes keep the sign of the 16-bit samples
                w.data = packed_fmt ? {smp.i[15:8], smp.q[15:8]} : smp.i; // R17 R18 R20
            end
            ppo_pkg::PH_Q: begin
                w.data = smp.q; // R19
            end
            ppo_pkg::PH_G: begin
                w.data = smp.gain;
            end
            default: begin
                w.data = '0;
            end
        endcase
        return w;
    endfunction : load_word

    always_comb begin
        logic [5:0] rem;
        logic [2:0] nxt;
        logic       fin;
        logic [ppo_pkg::DATA_W-1:0] wr;
        rem       = '0;
        nxt       = 3'h0;
        fin       = 1'b0;
        wr        = '0;
        next_st   = st;
        en_pend   = st.pending & st.ctrl.ch_en; // R22
        stat_word = '0;

        // port clock generation or detection
        case (st.ctrl.div)
            2'h0:    div_max = ppo_pkg::DIV_MAX_1;
            2'h1:    div_max = ppo_pkg::DIV_MAX_2;
            2'h2:    div_max = ppo_pkg::DIV_MAX_4;
            default: div_max = ppo_pkg::DIV_MAX_8;
        endcase
        if (st.ctrl.master) begin
            next_st.div_cnt = (st.div_cnt >= div_max) ? 3'h0 : st.div_cnt + 3'h1; // R2
        end else begin
            next_st.div_cnt = 3'h0;
        end
        next_st.pclk_pin  = st.ctrl.master && (next_st.div_cnt < ((div_max >> 1) + 3'h1)); // R2
        next_st.pclk_prev = pclk_sync;
        if (st.ctrl.master) begin
            tick = (next_st.div_cnt == 3'h0); // R1
        end else begin
            tick = pclk_sync && !st.pclk_prev; // R1 R3
        end

        // one holding slot per channel; disabled channels are dropped
        for (int c = 0; c < ppo_pkg::NUM_CH; c++) begin
            if (SMP_VALID_I[c] && !st.pending[c] && st.ctrl.ch_en[c]) begin
                next_st.pending[c] = 1'b1;
                next_st.held[c]    = SMP_DATA_I[c];
            end
        end

        // word sequencer, advances only on a port clock rise
        if (tick) begin // R5
            case (st.phase)
                ppo_pkg::PH_IDLE: begin
                    if (st.port.req && ack_sync && (|en_pend)) begin // R11 R12
                        nxt           = first_ch(en_pend);
                        next_st.phase = ppo_pkg::PH_I;
                        next_st.port  = load_word(ppo_pkg::PH_I, nxt, st.held[nxt],
                                                  st.ctrl.fmt_packed);
                    end else begin
                        next_st.port.req = |en_pend; // R6
                    end
                end
                ppo_pkg::PH_I: begin
                    if (ack_sync) begin // R8 R23
                        if (!st.ctrl.fmt_packed) begin
                            next_st.phase = ppo_pkg::PH_Q; // R9 R19
                            next_st.port  = load_word(ppo_pkg::PH_Q, st.port.ch,
                                                      st.held[st.port.ch], 1'b0);
                        end else if (st.ctrl.gain_en) begin
                            next_st.phase = ppo_pkg::PH_G; // R22
                            next_st.port  = load_word(ppo_pkg::PH_G, st.port.ch,
                                                      st.held[st.port.ch], 1'b1);
                        end else begin
                            fin = 1'b1;
                        end
                    end
                end
                ppo_pkg::PH_Q: begin
                    if (ack_sync) begin // R8 R23
                        if (st.ctrl.gain_en) begin
                            next_st.phase = ppo_pkg::PH_G; // R19
                            next_st.port  = load_word(ppo_pkg::PH_G, st.port.ch,
                                                      st.held[st.port.ch], 1'b0);
                        end else begin
                            fin = 1'b1;
                        end
                    end
                end
                ppo_pkg::PH_G: begin
                    if (ack_sync) begin // R8 R23
                        fin = 1'b1;
                    end
                end
                default: begin
                    next_st.phase = ppo_pkg::PH_IDLE;
                end
            endcase
            if (fin) begin
                next_st.pending[st.port.ch] = 1'b0;
                rem = en_pend & ~(6'h01 << st.port.ch);
                if (|rem) begin
                    // back to back channels keep request up
                    nxt           = first_ch(rem); // R7 R21
                    next_st.phase = ppo_pkg::PH_I;
                    next_st.port  = load_word(ppo_pkg::PH_I, nxt, st.held[nxt],
                                              st.ctrl.fmt_packed);
                end else begin
                    next_st.phase     = ppo_pkg::PH_IDLE;
                    next_st.port.req  = 1'b0;
                    next_st.port.iq   = 1'b0;
                    next_st.port.gain = 1'b0;
                end
            end
        end

        // axi write: address and data in either order, response after both
        if (AXI_AWVALID_I && AXI_AWREADY_O) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = AXI_AWADDR_I;
        end
        if (AXI_WVALID_I && AXI_WREADY_O) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = AXI_WDATA_I;
            next_st.w_strb = AXI_WSTRB_I;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            if (st.aw_addr[ppo_pkg::ADDR_W-1:2] == ppo_pkg::OFS_CTRL[ppo_pkg::ADDR_W-1:2]) begin
                wr = st.ctrl;
                for (int b = 0; b < 4; b++) begin
                    if (st.w_strb[b]) begin
                        wr[b*8 +: 8] = st.w_data[b*8 +: 8];
                    end
                end
                next_st.ctrl  = wr & ppo_pkg::CTRL_WR_MASK; // R22
                next_st.bresp = ppo_pkg::RESP_OKAY;
            end else if (st.aw_addr[ppo_pkg::ADDR_W-1:2]
                         == ppo_pkg::OFS_STAT[ppo_pkg::ADDR_W-1:2]) begin
                next_st.bresp = ppo_pkg::RESP_OKAY;
            end else begin
                next_st.bresp = ppo_pkg::RESP_SLVERR;
            end
        end else if (st.bvalid && AXI_BREADY_I) begin
            next_st.bvalid = 1'b0;
        end
        next_st.pclk_pin = next_st.pclk_pin && next_st.ctrl.master; // R4
        // axi read
        stat_word[ppo_pkg::STAT_PEND_LSB +: 6] = st.pending;
        stat_word[ppo_pkg::STAT_REQ_BIT]       = st.port.req;
        stat_word[ppo_pkg::STAT_CH_LSB +: 3]   = st.port.ch;
        if (AXI_ARVALID_I && AXI_ARREADY_O) begin
            next_st.rvalid = 1'b1;
            if (AXI_ARADDR_I[ppo_pkg::ADDR_W-1:2] == ppo_pkg::OFS_CTRL[ppo_pkg::ADDR_W-1:2]) begin
                next_st.rdata = st.ctrl;
                next_st.rresp = ppo_pkg::RESP_OKAY;
            end else if (AXI_ARADDR_I[ppo_pkg::ADDR_W-1:2]
                         == ppo_pkg::OFS_STAT[ppo_pkg::ADDR_W-1:2]) begin
                next_st.rdata = stat_word;
                next_st.rresp = ppo_pkg::RESP_OKAY;
            end else begin
                next_st.rdata = '0;
                next_st.rresp = ppo_pkg::RESP_SLVERR;
            end
        end else if (st.rvalid && AXI_RREADY_I) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            st         <= '0;
            st.ctrl    <= ppo_pkg::CTRL_RESET; // R4
            st.phase   <= ppo_pkg::PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign AXI_AWREADY_O       = !st.aw_got && !st.bvalid;
    assign AXI_WREADY_O        = !st.w_got && !st.bvalid;
    assign AXI_BVALID_O        = st.bvalid;
    assign AXI_BRESP_O         = st.bresp;
    assign AXI_ARREADY_O       = !st.rvalid;
    assign AXI_RVALID_O        = st.rvalid;
    assign AXI_RDATA_O         = st.rdata;
    assign AXI_RRESP_O         = st.rresp;
    assign SMP_READY_O         = ~st.pending;
    assign PCLK_O              = st.pclk_pin;
    assign PCLK_OE_O           = st.ctrl.master; // R1 R4
    assign SAMPLE_REQUEST_O    = st.port.req;
    assign INPHASE_WORD_FLAG_O = st.port.iq;
    assign GAIN_WORD_FLAG_O    = st.port.gain;
    assign SOURCE_CHANNEL_ID_O = st.port.ch;
    assign OUTPUT_WORD_BUS_O   = st.port.data;

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    sequence s_quiet3;
        !tick [*3];
    endsequence

    sequence s_accepted;
        tick && ack_sync;
    endsequence

    a_pin_released: assert property (!st.ctrl.master |-> !PCLK_OE_O && !PCLK_O) // R4
        else $error("port clock pin driven in slave mode");

    a_div_by_four: assert property (disable iff (RST_I || (st.aw_got && st.w_got)) // R2
        (st.ctrl.master && st.ctrl.div == 2'h2 && tick && !(st.aw_got && st.w_got))
        ##0 $stable(st.ctrl)
        |=> s_quiet3 ##1 tick)
        else $error("divide by four period wrong");

    a_pins_on_tick: assert property (!tick |=> $stable(st.port)) // R5
        else $error("port pins changed without port clock rise");

    a_stall_hold: assert property ( // R8
        (tick && !ack_sync && st.phase != ppo_pkg::PH_IDLE) |=> $stable(st.port)
        && $stable(st.phase))
        else $error("word moved while accept low");

    a_start_word: assert property ( // R12
        (s_accepted ##0 (st.port.req && st.phase == ppo_pkg::PH_IDLE && (|en_pend)))
        |=> INPHASE_WORD_FLAG_O && !GAIN_WORD_FLAG_O)
        else $error("first word missing after accept");

    a_q_follows_i: assert property ( // R19
        (s_accepted ##0 (st.phase == ppo_pkg::PH_I && !st.ctrl.fmt_packed))
        |=> st.phase == ppo_pkg::PH_Q && !INPHASE_WORD_FLAG_O
        && OUTPUT_WORD_BUS_O == st.held[SOURCE_CHANNEL_ID_O].q)
        else $error("quadrature word did not follow");

    a_gain_after_q: assert property ( // R15
        (s_accepted ##0 (st.phase == ppo_pkg::PH_Q && st.ctrl.gain_en))
        |=> GAIN_WORD_FLAG_O && !INPHASE_WORD_FLAG_O)
        else $error("gain word did not follow");

    a_req_held: assert property (st.phase != ppo_pkg::PH_IDLE |-> SAMPLE_REQUEST_O) // R7
        else $error("request dropped mid transfer");

    a_prio_zero: assert property ( // R21
        (s_accepted ##0 (st.phase == ppo_pkg::PH_IDLE && st.port.req && en_pend[0]))
        |=> SOURCE_CHANNEL_ID_O == 3'h0)
        else $error("channel zero not served first");

    a_packed_lanes: assert property ( // R20
        (st.phase == ppo_pkg::PH_I && st.ctrl.fmt_packed && $stable(st.port))
        |-> OUTPUT_WORD_BUS_O == {st.held[SOURCE_CHANNEL_ID_O].i[15:8],
                                  st.held[SOURCE_CHANNEL_ID_O].q[15:8]})
        else $error("packed byte lanes wrong");

endmodule : ppo_port

//--- verification/ppo_rx_model.sv
// receiving logic model for the sample port: drives accept, logs each new word
// assumes clk_i is the level on the shared port clock pin
`timescale 1ns/1ps
module ppo_rx_model (
    // port clock and stall mode
    input  wire logic        clk_i,
    input  wire logic        stall_i,
    // port pins
    input  wire logic        req_i,
    input  wire logic [20:0] word_i,
    output logic             accept_o
);
    logic [20:0] log_q[$];
    logic [21:0] last;
    logic        last_req;
    int          idle_n;
    int          max_idle;
    initial begin
        accept_o = 1'b1;
        last     = '0;
        last_req = 1'b0;
        idle_n   = 0;
        max_idle = 0;
    end
    // stall mode drops accept every other port cycle
    always @(posedge clk_i) begin
        accept_o <= stall_i ? ~accept_o : 1'b1;
    end
    // sampled at the fall so capture never races the launching rise
    always @(negedge clk_i) begin
        if (last_req && req_i && {req_i, word_i} != last) begin
            log_q.push_back(word_i);
            idle_n <= 0;
        end else if (req_i && !stall_i) begin
            // port cycles with request up and no new word
            idle_n   <= idle_n + 1;
            max_idle <= (idle_n + 1 > max_idle) ? idle_n + 1 : max_idle;
        end
        last     <= {req_i, word_i};
        last_req <= req_i;
    end
endmodule : ppo_rx_model

//--- verification/test_ppo_port.sv
// self-checking bench for the parallel sample output port
// assumes the receiver model is compiled first; stalls come only from stall mode
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_ppo_port;
    logic        clk, rst, awv, wv, brdy, arv, rrdy, ext_clk, ext_run, stall;
    logic        awrdy, wrdy, bv, arrdy, rv, pclk_o, pclk_oe, acc, req, iq, gn;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  resp, bresp, rresp;
    logic [5:0]  sv, srdy;
    logic [2:0]  chid;
    logic [15:0] dbus;
    logic [20:0] exp_q[$];
    ppo_pkg::ppo_sample_s [5:0] sd;
    int          err_count, tests_run, cyc;
    longint      t;
    wire         pclk = pclk_oe ? pclk_o : ext_clk;

    ppo_port uut (.CLK_SYS_I(clk), .RST_I(rst), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awrdy),
        .AXI_AWADDR_I(addr), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrdy), .AXI_WDATA_I(wdata),
        .AXI_WSTRB_I(4'hf), .AXI_BVALID_O(bv), .AXI_BREADY_I(brdy), .AXI_BRESP_O(bresp),
        .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arrdy), .AXI_ARADDR_I(addr), .AXI_RVALID_O(rv),
        .AXI_RREADY_I(rrdy), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .SMP_VALID_I(sv),
        .SMP_DATA_I(sd), .SMP_READY_O(srdy), .PCLK_I(pclk), .PCLK_O(pclk_o),
        .PCLK_OE_O(pclk_oe), .SAMPLE_ACCEPT_I(acc), .SAMPLE_REQUEST_O(req),
        .INPHASE_WORD_FLAG_O(iq), .GAIN_WORD_FLAG_O(gn), .SOURCE_CHANNEL_ID_O(chid),
        .OUTPUT_WORD_BUS_O(dbus));
    ppo_rx_model rx (.clk_i(pclk), .stall_i(stall), .req_i(req), .word_i({iq, gn, chid, dbus}),
        .accept_o(acc));

    task automatic results();
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        awv   <= wr;
        wv    <= wr;
        brdy  <= wr;
        arv   <= !wr;
        rrdy  <= !wr;
        do begin
            @(posedge clk);
            if (awv && awrdy) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (arv && arrdy) arv <= 1'b0;
        end while ((wr ? bv : rv) !== 1'b1);
        resp = wr ? bresp : rresp;
        rd   = rdata;
        brdy <= 1'b0;
        rrdy <= 1'b0;
    endtask : axi

    task automatic offer(input logic [5:0] m);
        int n;
        n = 0;
        @(posedge clk);
        sv <= m;
        do begin
            @(posedge clk);
            n++;
        end while ((srdy & m) !== m && n < 50);
        sv <= 6'h0;
    endtask : offer

    task automatic expect_ch(input int c, input bit pk, input bit g);
        ppo_pkg::ppo_sample_s s;
        s = sd[c];
        if (pk)
            exp_q.push_back({2'b10, 3'(c), s.i[15:8], s.q[15:8]});
        else begin
            exp_q.push_back({2'b10, 3'(c), s.i});
            exp_q.push_back({2'b00, 3'(c), s.q});
        end
        if (g)
            exp_q.push_back({2'b01, 3'(c), s.gain});
    endtask : expect_ch

    task automatic drain();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((rx.log_q.size() < exp_q.size() || req !== 1'b0) && n < 3000);
        `CHK(rx.log_q.size(), exp_q.size())
        foreach (exp_q[k]) if (k < rx.log_q.size()) `CHK(rx.log_q[k], exp_q[k])
        if (!stall) `CHK(rx.max_idle, 1)
        exp_q.delete();
        rx.log_q.delete();
    endtask : drain

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // external port clock, unrelated in phase, still outside its run
    initial begin
        ext_clk = 1'b0;
        forever #235 ext_clk = ext_run & ~ext_clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            results();
        end
    end

    initial begin
        {rst, awv, wv, brdy, arv, rrdy, ext_run, stall, sv, addr, wdata} = '0;
        rst = 1'b1;
        foreach (sd[c]) sd[c] = {8'h90 + 8'(c), 8'h3c, 8'h40 + 8'(c), 8'hc3, 13'h01c0, 3'(c)};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK(pclk_oe, 1'b0)
        `CHK(req, 1'b0)
        axi(0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        axi(0, 8'h40, 32'h0);
        `CHK(resp, 2'h2)
        axi(1, 8'h00, 32'h100);
        repeat (3) @(posedge clk);
        `CHK(pclk_oe, 1'b1)
        `CHK(pclk_o, 1'b1)
        for (int c = 1; c < 4; c++) begin
            axi(1, 8'h00, {21'h0, 2'(c), 9'h100});
            @(posedge pclk_o);
            t = $time;
            @(posedge pclk_o);
            `CHK(($time - t) / 40, 64'(1 << c))
        end
        axi(1, 8'h00, 32'h310);
        offer(6'h04);
        expect_ch(2, 0, 0);
        drain();
        axi(1, 8'h00, 32'h3fe);
        offer(6'h12);
        expect_ch(1, 0, 1);
        expect_ch(4, 0, 1);
        drain();
        axi(1, 8'h00, 32'h3ff);
        axi(0, 8'h00, 32'h0);
        `CHK(rd, 32'h3ff)
        stall = 1'b1;
        offer(6'h21);
        expect_ch(0, 1, 1);
        expect_ch(5, 1, 1);
        drain();
        stall = 1'b0;
        axi(1, 8'h00, 32'h020);
        ext_run = 1'b1;
        `CHK(pclk_oe, 1'b0)
        offer(6'h08);
        expect_ch(3, 0, 0);
        drain();
        ext_run = 1'b0;
        axi(1, 8'h00, 32'h304);
        offer(6'h02);
        repeat (40) @(posedge clk);
        `CHK(req, 1'b0)
        `CHK(rx.log_q.size(), 0)
        results();
    end
endmodule : test_ppo_port
